// ==== rtl/cmp_ctrl.sv ====
// dual comparator control: ahb-lite slave, pin routing, change interrupt
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`default_nettype none
module cmp_ctrl (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // analog comparator cores
   input wire logic [1:0] cmp_raw,
   output logic [1:0] cmp_enable,
   output logic [3:0] cmp_inv_sel,
   output logic [1:0] cmp_ref_plus_sel,
   // port pins
   input wire logic [7:0] port_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   output logic [7:0] analog_en,
   // interrupt
   output logic irq
);
   localparam int IRQ_W = cmp_pkg::IRQ_WIDTH;

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] port_direction;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [1:0] latched_out;
      logic [7:0] port_meta;
      logic [7:0] port_sync;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic [7:0] pin_out;
      logic [7:0] pin_oe_n;
      logic [7:0] analog_en;
      logic [1:0] cmp_enable;
      logic [3:0] inv_sel;
      logic [1:0] ref_plus;
      logic irq;
   } ctrl_s;

   ctrl_s st_r;
   ctrl_s st_nxt;
   logic [1:0] mux_enable;
   logic [3:0] mux_inv_sel;
   logic [1:0] mux_ref_plus;
   logic [7:0] mux_analog;
   logic mux_pin_en;
   logic [1:0] final_out;
   logic [1:0] sync_out;
   logic [1:0] sync_final;

   // mode decode and inversion of the raw results
   cmp_mux u_mux (
      .mode_sel(st_r.control[cmp_pkg::MODE_LSB +: 3]),
      .input_switch(st_r.control[cmp_pkg::INPUT_SWITCH_BIT]),
      .invert({st_r.control[cmp_pkg::SECOND_INVERT_BIT], st_r.control[cmp_pkg::FIRST_INVERT_BIT]}),
      .raw_out(cmp_raw),
      .cmp_enable(mux_enable),
      .inv_sel(mux_inv_sel),
      .ref_plus_sel(mux_ref_plus),
      .analog_pins(mux_analog),
      .pin_out_en(mux_pin_en),
      .final_out(final_out)
   );

   // raw results are asynchronous to hclk
   cmp_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(cmp_raw),
      .sync_out(sync_out)
   );

   // inversion applied after the synchroniser so the flops never see a mux glitch
   assign sync_final = sync_out & mux_enable ^
      {st_r.control[cmp_pkg::SECOND_INVERT_BIT], st_r.control[cmp_pkg::FIRST_INVERT_BIT]}; // [RQ18]

   // next state
   always_comb begin
      logic addr_phase;
      logic rd_ctrl;
      logic wr_ctrl;
      logic access_ctrl;
      logic mismatch;
      logic [7:0] port_view;
      addr_phase = 1'b0;
      rd_ctrl = 1'b0;
      wr_ctrl = 1'b0;
      access_ctrl = 1'b0;
      mismatch = 1'b0;
      port_view = 8'h00;
      st_nxt = st_r;

      // address phase capture, zero wait states
      addr_phase = hsel && hready && htrans[1];
      st_nxt.dp_valid = addr_phase;
      st_nxt.dp_write = hwrite;
      st_nxt.dp_addr = haddr;

      // pin inputs pass two flops
      st_nxt.port_meta = port_in;
      st_nxt.port_sync = st_r.port_meta;
      // analog pins read as zero
      port_view = st_r.port_sync & ~st_r.analog_en; // [RQ14]

      // write data phase
      if (st_r.dp_valid && st_r.dp_write) begin
         if (st_r.dp_addr == cmp_pkg::ADDR_CONTROL) begin
            wr_ctrl = 1'b1;
            st_nxt.control[5:0] = hwdata[5:0]; // [RQ11]
         end else if (st_r.dp_addr == cmp_pkg::ADDR_DIRECTION) begin
            st_nxt.port_direction = hwdata[7:0];
         end else if (st_r.dp_addr == cmp_pkg::ADDR_IRQ_MASK) begin
            st_nxt.irq_mask = hwdata[IRQ_W-1:0];
         end
      end
      rd_ctrl = st_r.dp_valid && !st_r.dp_write && st_r.dp_addr == cmp_pkg::ADDR_CONTROL;
      access_ctrl = rd_ctrl || wr_ctrl;

      // result bits follow synchronised, inverted outputs
      st_nxt.control[cmp_pkg::SECOND_RESULT_BIT] = sync_final[1]; // [RQ2]
      st_nxt.control[cmp_pkg::FIRST_RESULT_BIT] = sync_final[0]; // [RQ3]

      // mismatch against copy taken at last access
      mismatch = sync_final != st_r.latched_out; // [RQ18]
      if (access_ctrl) begin
         st_nxt.latched_out = sync_final; // [RQ16]
      end

      // read data, registered in the address phase cycle
      st_nxt.rdata = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         if (haddr == cmp_pkg::ADDR_CONTROL) begin
            st_nxt.rdata = {24'h00_0000, sync_final, st_r.control[5:0]};
         end else if (haddr == cmp_pkg::ADDR_DIRECTION) begin
            st_nxt.rdata = {24'h00_0000, st_r.port_direction};
         end else if (haddr == cmp_pkg::ADDR_PORT) begin
            st_nxt.rdata = {24'h00_0000, port_view};
         end else if (haddr == cmp_pkg::ADDR_IRQ_STATUS) begin
            st_nxt.rdata = {{(32 - IRQ_W){1'b0}}, st_r.irq_status};
         end else if (haddr == cmp_pkg::ADDR_IRQ_MASK) begin
            st_nxt.rdata = {{(32 - IRQ_W){1'b0}}, st_r.irq_mask};
         end
      end

      // write one to clear, a new change wins over the clear
      if (st_r.dp_valid && st_r.dp_write && st_r.dp_addr == cmp_pkg::ADDR_IRQ_STATUS) begin
         st_nxt.irq_status = st_r.irq_status & ~hwdata[IRQ_W-1:0];
      end
      if (mismatch && !access_ctrl) begin
         st_nxt.irq_status[cmp_pkg::IRQ_CHANGE_BIT] = 1'b1; // [RQ15]
      end
      st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);

      // analog side controls follow the mode
      st_nxt.cmp_enable = mux_enable;
      st_nxt.inv_sel = mux_inv_sel;
      st_nxt.ref_plus = mux_ref_plus;
      st_nxt.analog_en = mux_analog;

      // pin drivers: outputs in output modes, direction bit gates each driver
      st_nxt.pin_out = 8'h00;
      st_nxt.pin_oe_n = st_r.port_direction; // [RQ13]
      if (mux_pin_en) begin
         st_nxt.pin_out[cmp_pkg::PIN_FIRST_OUT] = final_out[0]; // [RQ12]
         st_nxt.pin_out[cmp_pkg::PIN_SECOND_OUT] = final_out[1];
      end
      // analog pins never drive
      st_nxt.pin_oe_n = st_nxt.pin_oe_n | mux_analog;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.control <= cmp_pkg::CONTROL_RESET; // [RQ17]
         st_r.port_direction <= cmp_pkg::DIRECTION_RESET;
         st_r.irq_mask <= cmp_pkg::IRQ_MASK_RESET;
         st_r.pin_oe_n <= 8'hff;
         st_r.analog_en <= 8'h7e;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops except the tied-off hreadyout and hresp; pin path is registered one cycle after the raw result
   assign hrdata = st_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cmp_enable = st_r.cmp_enable;
   assign cmp_inv_sel = st_r.inv_sel;
   assign cmp_ref_plus_sel = st_r.ref_plus;
   assign pin_out = st_r.pin_out;
   assign pin_oe_n = st_r.pin_oe_n;
   assign analog_en = st_r.analog_en;
   assign irq = st_r.irq;
endmodule : cmp_ctrl
`default_nettype wire

// ==== rtl/cmp_pkg.sv ====
// constants, register layout and mode codes for the dual comparator control block
// Contract
// [RQ1] two comparators take inputs from six shared pins or the internal reference
// [RQ2] status bit 7 shows comparator 2 result, reversed when its inversion is on
// [RQ3] status bit 6 shows comparator 1 result, reversed when its inversion is on
// [RQ4] control bit 5 inverts comparator 2 output before status bit and pin
// [RQ5] control bit 4 inverts comparator 1 output before status bit and pin
// [RQ6] control bit 3 swaps inverting input pins, only in mode 110
// [RQ7] control bits 2..0 choose one of eight input and output mux modes
// [RQ8] software should mask comparator interrupt while changing mode
// [RQ9] uninverted output is low when plus input below minus, high when above
// [RQ10] mode 110 puts internal reference on both non-inverting inputs
// [RQ11] result bits are read only; writes leave them alone
// [RQ12] in output modes pins carry comparator outputs unsynchronised
// [RQ13] pin direction bits still gate the pin drivers as enables
// [RQ14] port read returns zero for every pin set as analog input
// [RQ15] change flag sets whenever either comparator output changes; a change seen in a control access cycle is latched and sets no flag
// [RQ16] any read of the control register ends the mismatch condition
// [RQ17] reset returns control register to zero, mode 000, all inputs analog
// [RQ18] mismatch compares synchronised inverted outputs with copy latched at access
`default_nettype none
package cmp_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DIRECTION = 8'h04;
   localparam logic [7:0] ADDR_PORT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // control field positions
   localparam int SECOND_RESULT_BIT = 7;
   localparam int FIRST_RESULT_BIT = 6;
   localparam int SECOND_INVERT_BIT = 5;
   localparam int FIRST_INVERT_BIT = 4;
   localparam int INPUT_SWITCH_BIT = 3;
   localparam int MODE_LSB = 0;
   // interrupt status bit positions
   localparam int IRQ_CHANGE_BIT = 0;
   localparam int IRQ_WIDTH = 1;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'hff;
   localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 1'h0;
   // port pin indices used by the comparators
   localparam int PIN_FIRST_OUT = 1;
   localparam int PIN_SECOND_OUT = 2;
   // comparator modes
   typedef enum logic [2:0] {
      MODE_RESET = 3'b000,
      MODE_ONE_INDEP_OUT = 3'b001,
      MODE_TWO_INDEP = 3'b010,
      MODE_TWO_COMMON_REF = 3'b011,
      MODE_TWO_COMMON_REF_OUT = 3'b100,
      MODE_ONE_INDEP = 3'b101,
      MODE_FOUR_IN_MUX = 3'b110,
      MODE_OFF = 3'b111
   } cmp_mode_e;
endpackage : cmp_pkg
`default_nettype wire

// ==== rtl/cmp_sync.sv ====
// two flop synchroniser for the comparator outputs
`default_nettype none
module cmp_sync (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // data
   input wire logic [1:0] async_in,
   output logic [1:0] sync_out
);
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] stable;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;

   // first stage only feeds the second
   always_comb begin
      st_nxt.meta = async_in;
      st_nxt.stable = st_r.meta;
   end

   // register stages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stable;
endmodule : cmp_sync
`default_nettype wire

// ==== rtl/cmp_mux.sv ====
// analog mux selects and pin output routing per comparator mode
`default_nettype none
module cmp_mux (
   // configuration
   input wire logic [2:0] mode_sel,
   input wire logic input_switch,
   input wire logic [1:0] invert,
   // raw comparator results
   input wire logic [1:0] raw_out,
   // routing
   output logic [1:0] cmp_enable,
   output logic [3:0] inv_sel,
   output logic [1:0] ref_plus_sel,
   output logic [7:0] analog_pins,
   output logic pin_out_en,
   output logic [1:0] final_out
);
   // inversion applies ahead of the pins; the status bits invert the synchronised result in cmp_ctrl
   assign final_out = raw_out ^ invert; // [RQ4] [RQ5] [RQ9]

   // mux setup per mode; in mode 110 only, inv_sel sets two of four bits, one per comparator, over pins 3,4,5,6 with 1/2 as minus inputs
   always_comb begin
      cmp_enable = 2'b11;
      inv_sel = 4'h0;
      ref_plus_sel = 2'b00;
      analog_pins = 8'h7e; // [RQ1]
      pin_out_en = 1'b0;
      case (cmp_pkg::cmp_mode_e'(mode_sel)) // [RQ7]
         cmp_pkg::MODE_RESET: begin
            cmp_enable = 2'b00; // [RQ17]
         end
         cmp_pkg::MODE_ONE_INDEP_OUT: begin
            cmp_enable = 2'b01;
            pin_out_en = 1'b1;
            analog_pins = 8'h18;
         end
         cmp_pkg::MODE_ONE_INDEP: begin
            cmp_enable = 2'b01;
            analog_pins = 8'h18;
         end
         cmp_pkg::MODE_TWO_COMMON_REF_OUT: begin
            pin_out_en = 1'b1; // [RQ12]
            analog_pins = 8'h58;
         end
         cmp_pkg::MODE_FOUR_IN_MUX: begin
            ref_plus_sel = 2'b11; // [RQ10]
            inv_sel = input_switch ? 4'h6 : 4'h9; // [RQ6]
         end
         cmp_pkg::MODE_OFF: begin
            cmp_enable = 2'b00;
            analog_pins = 8'h00;
         end
         default: begin
            cmp_enable = 2'b11;
         end
      endcase
   end
endmodule : cmp_mux
`default_nettype wire

// ==== testbench/cmp_ctrl_sva.sv ====
// port-level assertion checker for the comparator control block
`default_nettype none
module cmp_ctrl_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // comparators and pins
   input wire logic [1:0] cmp_enable,
   input wire logic [1:0] cmp_ref_plus_sel,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] analog_en,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic ap;
   logic ctl_wr_r;
   // transfer taken at this edge
   assign ap = hsel && hready && htrans[1];
   // data phase of a control write; hwdata only stands one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ctl_wr_r <= 1'b0;
      else ctl_wr_r <= ap && hwrite && haddr == cmp_pkg::ADDR_CONTROL;
   end
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or error");
   property p_rst; $rose(hresetn) |-> analog_en == 8'h7e && !irq; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_oe; (analog_en & ~pin_oe_n) == 8'h00; endproperty
   a_oe: assert property (p_oe) else $error("analog pin driven");
   property p_port; ap && !hwrite && haddr == cmp_pkg::ADDR_PORT |=> (hrdata[7:0] & $past(analog_en)) == 8'h00;
   endproperty
   a_port: assert property (p_port) else $error("analog pin read nonzero");
   property p_unmap; ap && !hwrite && haddr > cmp_pkg::ADDR_IRQ_MASK |=> hrdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   property p_ref; ctl_wr_r && hwdata[2:0] == 3'b110 |-> ##[1:2] cmp_ref_plus_sel == 2'b11; endproperty
   a_ref: assert property (p_ref) else $error("reference not on plus inputs");
   property p_noref; ctl_wr_r && hwdata[2:0] != 3'b110 |-> ##[1:2] cmp_ref_plus_sel == 2'b00; endproperty
   a_noref: assert property (p_noref) else $error("reference outside its mode");
   property p_off; ctl_wr_r && hwdata[2:0] == 3'b111 |-> ##[1:2] cmp_enable == 2'b00; endproperty
   a_off: assert property (p_off) else $error("comparators not off");
   property p_on; ctl_wr_r && hwdata[2:0] == 3'b010 |-> ##[1:2] cmp_enable == 2'b11; endproperty
   a_on: assert property (p_on) else $error("comparators not on");
endmodule // cmp_ctrl_sva
`default_nettype wire

// ==== testbench/cmp_analog_model.sv ====
// behavioural model of the two analog comparator cores
`default_nettype none
module cmp_analog_model (
   // power enables from the block
   input wire logic [1:0] cmp_enable,
   // plus input above minus input, per comparator
   input wire logic [1:0] above,
   // raw results
   output logic [1:0] cmp_raw
);
   timeunit 1ns;
   timeprecision 100ps;
   // ideal core; a powered-down core sits low rather than holding its last level
   assign cmp_raw = cmp_enable & above;
endmodule // cmp_analog_model
`default_nettype wire

// ==== testbench/dual_comparator_control_tb.sv ====
// self-checking bench for the dual comparator control block
`default_nettype none
module dual_comparator_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] CTL = cmp_pkg::ADDR_CONTROL;
   localparam logic [7:0] DIR = cmp_pkg::ADDR_DIRECTION;
   localparam logic [7:0] STS = cmp_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] MSK = cmp_pkg::ADDR_IRQ_MASK;
   typedef struct {logic [7:0] ctl; logic [1:0] abv; logic [7:0] exp;} row_s;
   // control write, analog condition, control read-back
   row_s rows [10] = '{'{8'h02, 2'b01, 8'h42}, '{8'h12, 2'b01, 8'h12}, '{8'h22, 2'b10, 8'h22},
      '{8'h32, 2'b00, 8'hf2}, '{8'h01, 2'b11, 8'h41}, '{8'h13, 2'b10, 8'hd3}, '{8'h15, 2'b11, 8'h15},
      '{8'h07, 2'b11, 8'h07}, '{8'hc2, 2'b10, 8'h82}, '{8'h0e, 2'b11, 8'hce}};
   logic [3:0] isel;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] above = 2'b00;
   logic [7:0] port_in = 8'hff;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq;
   logic [1:0] cmp_raw, cmp_enable, cmp_ref_plus_sel;
   logic [3:0] cmp_inv_sel;
   logic [7:0] pin_out, pin_oe_n, analog_en;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   always #2.5 hclk = ~hclk;
   cmp_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
      .cmp_inv_sel(cmp_inv_sel), .cmp_ref_plus_sel(cmp_ref_plus_sel), .port_in(port_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_en(analog_en), .irq(irq));
   cmp_analog_model model_u (.cmp_enable(cmp_enable), .above(above), .cmp_raw(cmp_raw));
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask
   // one single transfer; ready and read data taken at the closing rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(a, 1'b1, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, {24'h0, e});
   endtask
   // room for the two-flop synchroniser, the flag and the registered outputs
   task automatic settle;
      repeat (6) @(posedge hclk);
   endtask
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(CTL, 8'h00);
      rd(DIR, 8'hff);
      rd(MSK, 8'h00);
      rd(8'h14, 8'h00);
      chk(32'(analog_en), 32'h7e);
      rd(cmp_pkg::ADDR_PORT, 8'h81);
      // mask still clear from reset, so mode changes raise no interrupt
      foreach (rows[i]) begin
         wr(CTL, rows[i].ctl);
         above <= rows[i].abv;
         settle();
         rd(CTL, rows[i].exp);
      end
      // change interrupt: set, cleared after a control read, then flagged again with the mask off
      wr(STS, 8'h01);
      wr(MSK, 8'h01);
      settle();
      chk(32'(irq), 32'h0);
      above <= 2'b01;
      settle();
      chk(32'(irq), 32'h1);
      rd(CTL, 8'h4e);
      wr(STS, 8'h01);
      settle();
      rd(STS, 8'h00);
      chk(32'(irq), 32'h0);
      wr(MSK, 8'h00);
      above <= 2'b00;
      settle();
      rd(STS, 8'h01);
      chk(32'(irq), 32'h0);
      // input switch picks the other, disjoint pair of minus-input pins
      isel = cmp_inv_sel;
      wr(CTL, 8'h06);
      settle();
      chk(32'($countones(isel)), 32'h2);
      chk({28'h0, isel ^ cmp_inv_sel}, 32'hf);
      // comparator outputs on the pins, gated by direction
      wr(DIR, 8'hf9);
      wr(CTL, 8'h04);
      above <= 2'b10;
      settle();
      chk({24'h0, cmp_inv_sel, pin_out[2:1], pin_oe_n[2:1]}, 32'h8);
      wr(CTL, 8'h34);
      settle();
      chk({30'h0, pin_out[2:1]}, 32'h1);
      wr(DIR, 8'hff);
      settle();
      chk({30'h0, pin_oe_n[2:1]}, 32'h3);
      // reset in mid-run
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(CTL, 8'h00);
      rd(DIR, 8'hff);
      rd(STS, 8'h00);
      chk(32'(irq), 32'h0);
      print_verdict();
   end
endmodule // dual_comparator_control_tb
bind cmp_ctrl cmp_ctrl_sva chk_u (.*);
`default_nettype wire
